// *** design/wait_cfg_pkg.sv ***
// Purpose: Shared constants and types for the area wait-count register bank.
// Assumes: One 32-bit AXI4-Lite register word per register, byte addressed.
// Notes:   Register data is 8 bits wide and sits in the low byte lane.

package wait_cfg_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------

  // Byte address width seen by the slave; the two low bits are ignored.
  localparam int ADDR_W = 12;
  localparam logic [11:0] WAIT_HIGH_OFFSET = 12'h000;
  localparam logic [11:0] WAIT_LOW_OFFSET = 12'h004;
  localparam logic [11:0] ACCESS_STATE_OFFSET = 12'h008;
  localparam logic [11:0] WAIT_STATUS_OFFSET = 12'h00c;

  // Values after reset and after hardware standby.
  localparam logic [7:0] WAIT_RESET = 8'hff;
  localparam logic [7:0] ACCESS_RESET = 8'hff;

  // ---------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------

  // Each area owns a 2-bit field; the high register holds areas 7 to 4.
  localparam int FIELD_W = 2;
  localparam int AREA_COUNT = 8;
  localparam int AREA_W = 3;

  // Status word: last applied count, last area, and wait-in-progress flag.
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_AREA_LSB = 2;
  localparam int STAT_ACTIVE_BIT = 5;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------

  // One bus cycle start announced by the external bus sequencer.
  typedef struct packed {
    logic start;
    logic external;
    logic [2:0] area;
  } bus_cycle_t;

  // Wait request handed back to the sequencer.
  typedef struct packed {
    logic active;
    logic [1:0] count;
  } wait_out_t;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_WAIT = 1'b1
  } wait_state_t;

endpackage

// *** design/wait_select.sv ***
// Purpose: Picks the program wait count for the area of one bus cycle.
// Assumes: Register values are stable for the cycle in which they are read.
// Notes:   Purely combinational; the caller registers the result.

`timescale 1ns/100ps
`default_nettype none

module wait_select
  import wait_cfg_pkg::*;
(
  input wire logic [7:0] wait_high,
  input wire logic [7:0] wait_low,
  input wire logic [7:0] access_state,
  input wire logic external,
  input wire logic [2:0] area,
  output logic [1:0] count
);

  import wait_cfg_pkg::*;

  // ---------------------------------------------------------------------
  // Per-area fields
  // ---------------------------------------------------------------------

  logic [15:0] both_regs;
  logic [1:0] field [AREA_COUNT];

  // Area n lives in bits 2n+1:2n of the joined pair, upper bit weightier.
  assign both_regs = {wait_high, wait_low}; // RL7 RL8
  for (genvar n = 0; n < AREA_COUNT; n++)
  begin : g_field
    assign field[n] = both_regs[FIELD_W*n +: FIELD_W];
  end

  // ---------------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------------

  // Internal targets and 2-state areas never see program waits.
  always_comb
  begin
    count = 2'b00; // RL2
    if (external && access_state[area]) // RL5 RL9
    begin
      count = field[area]; // RL6
    end
  end

endmodule

`default_nettype wire

// *** design/area_wait_state_config.sv ***
// Purpose: Area wait-count register bank with an AXI4-Lite slave port.
// Assumes: The sequencer pulses CYCLE.start once per bus cycle, internal or external.
// Notes:   The selected count is frozen at the start of each bus cycle.
//
// What this block does
// [RL1] Two 8-bit read/write registers hold a 2-bit wait count per area.
// [RL2] Accesses to internal memory or registers never get program waits.
// [RL3] Reset and hardware standby load both wait registers with all ones.
// [RL4] Software standby keeps the written contents of both registers.
// [RL5] A wait field applies only while its area's 3-state bit is one.
// [RL6] Field codes 00, 01, 10, 11 add zero to three wait states.
// [RL7] High register: area 7 in 7:6 down to area 4 in 1:0.
// [RL8] Low register: area 3 in 7:6 down to area 0 in 1:0.
// [RL9] Access-state bit zero means 2-state, no waits; one means 3-state.
// [RL10] Writes apply from the next bus cycle; reads return last written.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.

`timescale 1ns/100ps
`default_nettype none

module area_wait_state_config
  import wait_cfg_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HW_STANDBY,
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire wait_cfg_pkg::bus_cycle_t CYCLE,
  output wait_cfg_pkg::wait_out_t WAIT_OUT
);

  import wait_cfg_pkg::*;

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------

  logic aw_held_reg;
  logic aw_held_next;
  logic [11:0] aw_addr_reg;
  logic [11:0] aw_addr_next;
  logic w_held_reg;
  logic w_held_next;
  logic [7:0] w_data_reg;
  logic [7:0] w_data_next;
  logic w_lane_reg;
  logic w_lane_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic [7:0] wait_high_areas_reg;
  logic [7:0] wait_high_areas_next;
  logic [7:0] wait_low_areas_reg;
  logic [7:0] wait_low_areas_next;
  logic [7:0] access_state_select_reg;
  logic [7:0] access_state_select_next;

  wait_state_t state_reg;
  wait_state_t state_next;
  logic [1:0] remain_reg;
  logic [1:0] remain_next;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic [2:0] area_reg;
  logic [2:0] area_next;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic commit;
  logic [1:0] selected_count;
  logic [7:0] status_byte;

  // ---------------------------------------------------------------------
  // Bus handshakes
  // ---------------------------------------------------------------------

  // Address and data are each held until both have arrived, in any order.
  assign AWREADY = !aw_held_reg && !bvalid_reg;
  assign WREADY = !w_held_reg && !bvalid_reg;
  assign ARREADY = !rvalid_reg;
  assign aw_take = AWVALID && AWREADY;
  assign w_take = WVALID && WREADY;
  assign ar_take = ARVALID && ARREADY;
  assign commit = aw_held_reg && w_held_reg && !bvalid_reg;

  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;
  assign RVALID = rvalid_reg;
  assign RRESP = rresp_reg;
  assign RDATA = rdata_reg;

  // ---------------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------------

  // Capture address and data, then commit once both are held.
  always_comb
  begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (aw_take)
    begin
      aw_held_next = 1'b1;
      aw_addr_next = AWADDR;
    end
    if (w_take)
    begin
      w_held_next = 1'b1;
      w_data_next = WDATA[7:0];
      w_lane_next = WSTRB[0];
    end
    if (commit)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      unique case (aw_addr_reg[11:2])
        WAIT_HIGH_OFFSET[11:2],
        WAIT_LOW_OFFSET[11:2],
        ACCESS_STATE_OFFSET[11:2],
        WAIT_STATUS_OFFSET[11:2]:
          bresp_next = RESP_OKAY;
        default:
          bresp_next = RESP_SLVERR; // Unmapped word.
      endcase
    end
    else if (bvalid_reg && BREADY)
    begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_lane_reg <= w_lane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // ---------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------

  // Only byte lane 0 carries data; a write without it changes nothing.
  always_comb
  begin
    wait_high_areas_next = wait_high_areas_reg; // RL10
    wait_low_areas_next = wait_low_areas_reg;
    access_state_select_next = access_state_select_reg;
    if (commit && w_lane_reg)
    begin
      unique case (aw_addr_reg[11:2])
        WAIT_HIGH_OFFSET[11:2]:
          wait_high_areas_next = w_data_reg; // RL1 RL7
        WAIT_LOW_OFFSET[11:2]:
          wait_low_areas_next = w_data_reg; // RL1 RL8
        ACCESS_STATE_OFFSET[11:2]:
          access_state_select_next = w_data_reg; // RL9
        default:
          wait_low_areas_next = wait_low_areas_reg;
      endcase
    end
  end

  // Hardware standby presets like reset; there is no software standby
  // input at all, so that mode can never disturb the contents.
  always_ff @(posedge MCLK)
  begin
    if (RST || HW_STANDBY) // RL3
    begin
      wait_high_areas_reg <= WAIT_RESET; // RL3
      wait_low_areas_reg <= WAIT_RESET; // RL3
      access_state_select_reg <= ACCESS_RESET;
    end
    else
    begin
      wait_high_areas_reg <= wait_high_areas_next; // RL4
      wait_low_areas_reg <= wait_low_areas_next; // RL4
      access_state_select_reg <= access_state_select_next;
    end
  end

  // ---------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------

  // Status shows the count and area applied to the latest bus cycle.
  assign status_byte = {2'b00, state_reg == SEQ_WAIT, area_reg, count_reg};

  always_comb
  begin
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (ar_take)
    begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      unique case (ARADDR[11:2])
        WAIT_HIGH_OFFSET[11:2]:
          rdata_next = {24'h000000, wait_high_areas_reg}; // RL10
        WAIT_LOW_OFFSET[11:2]:
          rdata_next = {24'h000000, wait_low_areas_reg}; // RL10
        ACCESS_STATE_OFFSET[11:2]:
          rdata_next = {24'h000000, access_state_select_reg};
        WAIT_STATUS_OFFSET[11:2]:
          rdata_next = {24'h000000, status_byte};
        default:
        begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && RREADY)
    begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------------
  // Wait insertion
  // ---------------------------------------------------------------------

  wait_select u_select (
    .wait_high(wait_high_areas_reg),
    .wait_low(wait_low_areas_reg),
    .access_state(access_state_select_reg),
    .external(CYCLE.external),
    .area(CYCLE.area),
    .count(selected_count)
  );

  // The count is frozen at the cycle start, so a register write in the
  // middle of a bus cycle cannot stretch or cut that cycle short.
  always_comb
  begin
    state_next = state_reg;
    remain_next = remain_reg;
    count_next = count_reg;
    area_next = area_reg;
    if (CYCLE.start)
    begin
      count_next = selected_count; // RL10
      area_next = CYCLE.area;
      remain_next = selected_count; // RL6
      state_next = (selected_count == 2'b00) ? SEQ_IDLE : SEQ_WAIT; // RL2
    end
    else
    begin
      unique case (state_reg)
        SEQ_IDLE:
          remain_next = 2'b00;
        SEQ_WAIT:
        begin
          remain_next = remain_reg - 2'b01;
          if (remain_reg == 2'b01)
          begin
            state_next = SEQ_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state_reg <= SEQ_IDLE;
      remain_reg <= 2'b00;
      count_reg <= 2'b00;
      area_reg <= 3'b000;
    end
    else
    begin
      state_reg <= state_next;
      remain_reg <= remain_next;
      count_reg <= count_next;
      area_reg <= area_next;
    end
  end

  // Active for exactly count cycles after the start edge.
  assign WAIT_OUT = {state_reg == SEQ_WAIT, count_reg};

endmodule

`default_nettype wire

// *** dv/area_wait_state_config_properties.sv ***
// Purpose: Port-level properties of the area wait-count register bank.
// Assumes: One clock, MCLK; RST is synchronous and active high.
// Notes:   Bound from the bench top and watches the ports only, inputs and outputs.
`timescale 1ns/100ps
`default_nettype none
module area_wait_state_config_properties
  import wait_cfg_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire wait_cfg_pkg::bus_cycle_t CYCLE,
  input wire wait_cfg_pkg::wait_out_t WAIT_OUT
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // Reset masks all checks but the first, which is about reset itself.
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // Three waits end exactly after the third cycle of the count.
  sequence s_three_waits;
    CYCLE.start ##1 (WAIT_OUT.count == 2'h3 && !CYCLE.start) [*3];
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    RST |=> !BVALID && !RVALID && WAIT_OUT == 3'h0)
    else $error("Outputs not idle after reset.");
  a_read_latency: assert property (
    ARVALID && ARREADY |=> RVALID)
    else $error("Read answer late.");
  a_read_hold: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("Read data dropped before taken.");
  a_read_refuse: assert property (RVALID |-> !ARREADY)
    else $error("Second read accepted.");
  // Address and data are held one cycle before the commit raises BVALID.
  a_write_answer: assert property (
    AWVALID && AWREADY && WVALID && WREADY |=> !BVALID ##1 BVALID)
    else $error("Write answer late.");
  a_write_hold: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("Write response dropped before taken.");
  a_internal_none: assert property (
    CYCLE.start && !CYCLE.external |=> WAIT_OUT == 3'h0)
    else $error("Internal access got waits.");
  a_one_wait: assert property (
    CYCLE.start ##1 (WAIT_OUT.count == 2'h1 && !CYCLE.start)
    |-> WAIT_OUT.active ##1 !WAIT_OUT.active)
    else $error("One-wait length wrong.");
  a_three_waits: assert property (
    s_three_waits |-> WAIT_OUT.active ##1 !WAIT_OUT.active)
    else $error("Three-wait length wrong.");
  a_zero_idle: assert property (
    WAIT_OUT.count == 2'h0 |-> !WAIT_OUT.active)
    else $error("Wait active with zero count.");
  a_count_stands: assert property (
    !CYCLE.start |=> $stable(WAIT_OUT.count))
    else $error("Wait count changed without a start.");
  c_read: cover property (RVALID && RREADY);
  c_write: cover property (BVALID && BREADY);
  c_three: cover property (s_three_waits);
endmodule
`default_nettype wire

// *** dv/area_bus_model.sv ***
// Purpose: External bus sequencer side that starts cycles, counts waits.
// Assumes: The bench calls access() between its register transfers.
// Notes:   Samples one time unit after each edge, once outputs settle.
`timescale 1ns/100ps
`default_nettype none
module area_bus_model
  import wait_cfg_pkg::*;
(
  input wire logic clk,
  output wait_cfg_pkg::bus_cycle_t cycle,
  input wire wait_cfg_pkg::wait_out_t wait_in
);
  // Idle qualifiers are inverted so a stale area is never mistaken.
  initial cycle = 5'h00;
  // One start pulse, then five cycles of watching for over-long waits.
  task automatic access(input logic [2:0] area, input logic ext,
                        output int waits);
    waits = 0;
    @(posedge clk);
    cycle <= {1'b1, ext, area};
    @(posedge clk);
    cycle <= {1'b0, ~ext, ~area};
    #1;
    repeat (5)
    begin
      if (wait_in.active === 1'b1)
        waits++;
      @(posedge clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// *** dv/area_wait_state_config_tb_top.sv ***
// Purpose: Self-checking bench for the area wait-count register bank.
// Assumes: Register access over AXI4-Lite, one transfer at a time.
// Notes:   Expected waits come from shadow copies of the registers.
`timescale 1ns/100ps
`default_nettype none
module area_wait_state_config_tb_top;
  import wait_cfg_pkg::*;
  logic mclk, rst, hw_standby, awvalid, awready, wvalid, wready;
  logic bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  bus_cycle_t cycle;
  wait_out_t wait_out;
  logic [7:0] hi, lo, ast;
  logic [31:0] data;
  int fails, comparisons, cycles;
  area_wait_state_config area_wait_state_config_i (.MCLK(mclk), .RST(rst),
    .HW_STANDBY(hw_standby), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CYCLE(cycle), .WAIT_OUT(wait_out));
  area_bus_model area_bus_model_i (.clk(mclk), .cycle(cycle),
    .wait_in(wait_out));
  // ---------------------------------------------------------------
  // Clock, timeout and checking
  // ---------------------------------------------------------------
  // The clock toggles every 5 ns, a period of 10 ns.
  always #5 mclk = ~mclk;
  // A hang is cut short long after the sequence should have ended.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is looked at mid-cycle, so the edge that takes it is known.
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, done;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge mclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end while (!done);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, done;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge mclk);
      ta = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta)
        arvalid <= 1'b0;
    end while (!done);
    rready <= 1'b0;
  endtask
  // A plain write also updates the shadow register behind it.
  task automatic put(input logic [11:0] a, input logic [7:0] d);
    wr(a, d, 4'h1, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    if (a == WAIT_HIGH_OFFSET)
      hi = d;
    else if (a == WAIT_LOW_OFFSET)
      lo = d;
    else
      ast = d;
  endtask
  task automatic get(input logic [11:0] a, input logic [7:0] exp);
    rd(a, data, resp);
    chk(data, {24'h000000, exp});
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask
  task automatic acc(input logic [2:0] a, input logic ext);
    int w;
    logic [1:0] e;
    e = (ext && ast[a]) ? 2'({hi, lo} >> (2 * a)) : 2'h0;
    area_bus_model_i.access(a, ext, w);
    chk(32'(w), {30'h0, e});
    chk({30'h0, wait_out.count}, {30'h0, e});
  endtask
  task automatic do_reset(input logic standby);
    @(posedge mclk);
    rst <= ~standby;
    hw_standby <= standby;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    hw_standby <= 1'b0;
    hi = 8'hff;
    lo = 8'hff;
    ast = 8'hff;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {mclk, hw_standby, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    rst = 1'b1;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    do_reset(1'b0);
    get(WAIT_HIGH_OFFSET, 8'hff);
    get(WAIT_LOW_OFFSET, 8'hff);
    acc(3'h5, 1'b1);
    put(WAIT_HIGH_OFFSET, 8'h1b);
    put(WAIT_LOW_OFFSET, 8'he4);
    get(WAIT_HIGH_OFFSET, 8'h1b);
    get(WAIT_LOW_OFFSET, 8'he4);
    for (int i = 0; i < 8; i++)
      acc(3'(i), 1'b1);
    acc(3'h4, 1'b0);
    put(ACCESS_STATE_OFFSET, 8'hef);
    acc(3'h4, 1'b1);
    acc(3'h3, 1'b1);
    get(WAIT_STATUS_OFFSET, 8'h0f);
    wr(WAIT_LOW_OFFSET, 8'h00, 4'h0, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    get(WAIT_LOW_OFFSET, 8'he4);
    wr(12'h010, 8'h00, 4'h1, resp);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(12'h010, data, resp);
    chk(data, 32'h00000000);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    put(WAIT_LOW_OFFSET, 8'h00);
    acc(3'h3, 1'b1);
    repeat (20) @(posedge mclk);
    get(WAIT_LOW_OFFSET, 8'h00);
    do_reset(1'b1);
    get(WAIT_LOW_OFFSET, 8'hff);
    acc(3'h4, 1'b1);
    put(WAIT_HIGH_OFFSET, 8'h40);
    do_reset(1'b0);
    get(WAIT_HIGH_OFFSET, 8'hff);
    give_verdict();
  end
endmodule
bind area_wait_state_config area_wait_state_config_properties props_i
(
  .MCLK(MCLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
  .RVALID(RVALID), .RREADY(RREADY), .CYCLE(CYCLE), .WAIT_OUT(WAIT_OUT)
);
`default_nettype wire
